/* File: rtl/tcs_timer.sv */
// Contract
// - Bottom signalled whenever count becomes zero
// - Top is fixed maximum, compare A or capture
// - 16-bit data registers, free 8-bit controls
// - Overflow, match A, match B, capture sources
// - Each request is a flag, individually masked
// - Prescaler or external pin ticks; none idles
// - Buffered compares set flag and drive waveform
// - Filtered pin/comparator edge captures the count unless capture is top
// - Compare A as PWM top: no output, buffered
// - Capture register may serve as top
// - One shared high-byte latch per timer
// - Low-byte write loads whole register
// - Count/capture low-byte read copies high byte to latch
// - Compare reads bypass the shared latch
// - Clear on match and phase-correct PWM
// - Counter high address reaches the latch
// - Up/down counter by one, with clear
module tcs_timer #(
    parameter int NC_DEPTH = tcs_pkg::NC_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tcs_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tcs_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_count_pin,
    input wire logic capture_input_pin,
    input wire logic comparator_out,
    output logic waveform_out_a,
    output logic waveform_out_a_en,
    output logic waveform_out_b,
    output logic waveform_out_b_en,
    output logic count_bottom,
    output logic count_top,
    output logic [3:0] irq
);
    import tcs_pkg::*;

    generate
        if (NC_DEPTH < 2 || NC_DEPTH > 8)
        begin : g_bad_depth
            $error("NC_DEPTH must lie in 2..8");
        end
    endgenerate

    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [15:0] count_value;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [15:0] cmp_act_a;
    logic [15:0] cmp_act_b;
    logic [15:0] capture_value;
    logic [7:0] hi_latch;
    logic [3:0] timer_flag_register;
    logic [3:0] timer_mask_register;
    logic timer_power_off_bit;
    logic count_up;
    logic [9:0] prescale;
    logic ext_q;
    logic ext_prev;
    logic [NC_DEPTH-1:0] cap_hist;
    logic cap_level;
    logic cap_prev;
    logic aw_full;
    logic w_full;
    logic [5:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;

    // Register bus decode
    wire do_write = aw_full && w_full && !s_axi_bvalid;
    wire wr_en = do_write && w_lane0;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [5:0] rd_addr = s_axi_araddr;
    wire wr_ca = wr_en && aw_addr == OFS_CTRL_A;
    wire wr_cb = wr_en && aw_addr == OFS_CTRL_B;
    wire wr_cnt_l = wr_en && aw_addr == OFS_CNT_L;
    wire wr_cma_l = wr_en && aw_addr == OFS_CMPA_L;
    wire wr_cmb_l = wr_en && aw_addr == OFS_CMPB_L;
    wire wr_cap_l = wr_en && aw_addr == OFS_CAP_L;
    wire wr_flag = wr_en && aw_addr == OFS_FLAG;
    wire wr_mask = wr_en && aw_addr == OFS_MASK;
    wire wr_pwr = wr_en && aw_addr == OFS_PWR;
    wire wr_hi = wr_en && (aw_addr == OFS_CNT_H || aw_addr == OFS_CMPA_H
        || aw_addr == OFS_CMPB_H || aw_addr == OFS_CAP_H);
    wire rd_cnt_l = rd_take && rd_addr == OFS_CNT_L;
    wire rd_cap_l = rd_take && rd_addr == OFS_CAP_L;
    wire aw_map = aw_addr <= OFS_PWR && aw_addr[1:0] == 2'b00;
    wire ar_map = rd_addr <= OFS_PWR && rd_addr[1:0] == 2'b00;

    // Mode decode
    wire [2:0] mode = timer_control_a[CA_MODE_LSB +: 3];
    wire [1:0] com_a = timer_control_a[CA_COMA_LSB +: 2];
    wire [1:0] com_b = timer_control_a[CA_COMB_LSB +: 2];
    wire [2:0] clk_sel = timer_control_b[CB_CS_LSB +: 3];
    wire pwm = mode == MD_PC_MAX || mode == MD_PC_A || mode == MD_PC_CAP;
    wire top_is_a = mode == MD_CTC_A || mode == MD_PC_A;
    wire top_is_cap = mode == MD_CTC_CAP || mode == MD_PC_CAP;
    wire [15:0] top_val = top_is_a ? cmp_act_a
        : (top_is_cap ? capture_value : COUNT_MAX);
    wire at_top = count_value == top_val;
    wire at_bottom = count_value == 16'h0000;

    // Timer tick selection
    wire ext_rise = ext_q && !ext_prev;
    wire ext_fall = !ext_q && ext_prev;
    logic tick_sel;
    always_comb
    begin
        case (clk_sel)
            CS_DIV1: tick_sel = 1'b1;
            CS_DIV8: tick_sel = prescale[2:0] == 3'h7;
            CS_DIV64: tick_sel = prescale[5:0] == 6'h3f;
            CS_DIV256: tick_sel = prescale[7:0] == 8'hff;
            CS_DIV1024: tick_sel = prescale == 10'h3ff;
            CS_EXT_FALL: tick_sel = ext_fall;
            CS_EXT_RISE: tick_sel = ext_rise;
            default: tick_sel = 1'b0;
        endcase
    end
    wire timer_tick = tick_sel && !timer_power_off_bit;

    // Counter next value
    logic [15:0] next_count;
    logic next_up;
    logic ovf_ev;
    always_comb
    begin
        next_count = count_value;
        next_up = count_up;
        ovf_ev = 1'b0;
        if (pwm)
        begin
            if (count_up)
            begin
                if (at_top)
                begin
                    next_up = 1'b0;
                    next_count = at_bottom ? count_value : count_value - 16'h0001;
                end
                else
                begin
                    next_count = count_value + 16'h0001;
                end
            end
            else if (at_bottom)
            begin
                next_up = 1'b1;
                ovf_ev = 1'b1;
                next_count = at_top ? count_value : count_value + 16'h0001;
            end
            else
            begin
                next_count = count_value - 16'h0001;
            end
        end
        else
        begin
            next_up = 1'b1;
            ovf_ev = count_value == COUNT_MAX;
            // Clear on match reloads from zero
            next_count = (at_top ? 16'h0000 : count_value + 16'h0001);
        end
    end

    // Compare, capture and flag events
    wire match_a = timer_tick && count_value == cmp_act_a;
    wire match_b = timer_tick && count_value == cmp_act_b;
    wire cap_raw = timer_control_b[CB_CAPSRC_BIT] ? comparator_out : capture_input_pin;
    wire hist_same = cap_hist == {NC_DEPTH{cap_hist[0]}};
    wire cap_filt = timer_control_b[CB_NOISE_BIT] ? (hist_same ? cap_hist[0] : cap_level)
        : cap_hist[0];
    wire cap_edge = timer_control_b[CB_CAPEDGE_BIT] ? (cap_level && !cap_prev)
        : (!cap_level && cap_prev);
    wire cap_ev = cap_edge && !timer_power_off_bit;
    wire [3:0] flag_set = {cap_ev, match_b, match_a, timer_tick && ovf_ev};
    wire [3:0] flag_clr = wr_flag ? w_byte[3:0] : 4'h0;
    // Set beats a same-cycle clear so no event is lost
    wire [3:0] next_flags = (timer_flag_register & ~flag_clr) | flag_set;
    wire load_buf = !pwm || (timer_tick && at_top);

    function automatic logic wave_next(input logic cur, input logic [1:0] com,
        input logic is_pwm, input logic up);
        logic res;
        res = cur;
        if (is_pwm)
        begin
            if (com[1])
            begin
                res = up ? com[0] : !com[0];
            end
        end
        else
        begin
            case (com)
                2'b01: res = !cur;
                2'b10: res = 1'b0;
                2'b11: res = 1'b1;
                default: res = cur;
            endcase
        end
        return res;
    endfunction

    // Read data mux
    logic [7:0] rd_byte;
    always_comb
    begin
        case (rd_addr)
            OFS_CTRL_A: rd_byte = timer_control_a;
            OFS_CTRL_B: rd_byte = timer_control_b;
            OFS_CNT_L: rd_byte = count_value[7:0];
            OFS_CNT_H: rd_byte = hi_latch;
            OFS_CMPA_L: rd_byte = compare_value_a[7:0];
            OFS_CMPA_H: rd_byte = compare_value_a[15:8];
            OFS_CMPB_L: rd_byte = compare_value_b[7:0];
            OFS_CMPB_H: rd_byte = compare_value_b[15:8];
            OFS_CAP_L: rd_byte = capture_value[7:0];
            OFS_CAP_H: rd_byte = hi_latch;
            OFS_FLAG: rd_byte = {4'h0, timer_flag_register};
            OFS_MASK: rd_byte = {4'h0, timer_mask_register};
            OFS_PWR: rd_byte = {7'h00, timer_power_off_bit};
            default: rd_byte = 8'h00;
        endcase
    end

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign count_bottom = at_bottom;
    assign count_top = at_top;
    assign irq = timer_flag_register & timer_mask_register;
    assign waveform_out_a_en = com_a != 2'b00 && !(pwm && top_is_a);
    assign waveform_out_b_en = com_b != 2'b00;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 6'h00;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_map ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= ar_map ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timer_control_a <= RST_CTRL;
            timer_control_b <= RST_CTRL;
            timer_mask_register <= RST_FLAG;
            timer_flag_register <= RST_FLAG;
            timer_power_off_bit <= PWR_OFF_RST;
            hi_latch <= 8'h00;
        end
        else
        begin
            if (wr_ca)
                timer_control_a <= w_byte;
            if (wr_cb)
                timer_control_b <= w_byte;
            if (wr_mask)
                timer_mask_register <= w_byte[3:0];
            if (wr_pwr)
                timer_power_off_bit <= w_byte[PWR_OFF_BIT];
            timer_flag_register <= next_flags;
            // A single latch serves all four wide registers
            if (wr_hi)
                hi_latch <= w_byte;
            else if (rd_cnt_l)
                hi_latch <= count_value[15:8];
            else if (rd_cap_l)
                hi_latch <= capture_value[15:8];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count_value <= RST_WORD;
            count_up <= 1'b1;
            compare_value_a <= RST_WORD;
            compare_value_b <= RST_WORD;
            cmp_act_a <= RST_WORD;
            cmp_act_b <= RST_WORD;
            capture_value <= RST_WORD;
        end
        else
        begin
            // Software write takes precedence over a tick
            if (wr_cnt_l)
                count_value <= {hi_latch, w_byte};
            else if (timer_tick)
            begin
                count_value <= next_count;
                count_up <= next_up;
            end
            if (wr_cma_l)
                compare_value_a <= {hi_latch, w_byte};
            if (wr_cmb_l)
                compare_value_b <= {hi_latch, w_byte};
            if (load_buf)
            begin
                cmp_act_a <= compare_value_a;
                cmp_act_b <= compare_value_b;
            end
            if (wr_cap_l)
                capture_value <= {hi_latch, w_byte};
            else if (cap_ev && !top_is_cap)
                capture_value <= count_value;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prescale <= 10'h000;
            ext_q <= 1'b0;
            ext_prev <= 1'b0;
            cap_hist <= '0;
            cap_level <= 1'b0;
            cap_prev <= 1'b0;
            waveform_out_a <= 1'b0;
            waveform_out_b <= 1'b0;
        end
        else
        begin
            // Free running so enabling a tap gives a 1..N cycle first delay
            prescale <= prescale + 10'h001;
            ext_q <= external_count_pin;
            ext_prev <= ext_q;
            cap_hist <= {cap_hist[NC_DEPTH-2:0], cap_raw};
            cap_level <= cap_filt;
            cap_prev <= cap_level;
            if (match_a && waveform_out_a_en)
                waveform_out_a <= wave_next(waveform_out_a, com_a, pwm, count_up);
            if (match_b && waveform_out_b_en)
                waveform_out_b <= wave_next(waveform_out_b, com_b, pwm, count_up);
        end
    end
endmodule // tcs_timer

/* File: rtl/tcs_pkg.sv */
package tcs_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    // Byte addresses of the register words
    localparam logic [5:0] OFS_CTRL_A = 6'h00;
    localparam logic [5:0] OFS_CTRL_B = 6'h04;
    localparam logic [5:0] OFS_CNT_L = 6'h08;
    localparam logic [5:0] OFS_CNT_H = 6'h0c;
    localparam logic [5:0] OFS_CMPA_L = 6'h10;
    localparam logic [5:0] OFS_CMPA_H = 6'h14;
    localparam logic [5:0] OFS_CMPB_L = 6'h18;
    localparam logic [5:0] OFS_CMPB_H = 6'h1c;
    localparam logic [5:0] OFS_CAP_L = 6'h20;
    localparam logic [5:0] OFS_CAP_H = 6'h24;
    localparam logic [5:0] OFS_FLAG = 6'h28;
    localparam logic [5:0] OFS_MASK = 6'h2c;
    localparam logic [5:0] OFS_PWR = 6'h30;
    // Field positions
    localparam int CA_MODE_LSB = 0;
    localparam int CA_COMB_LSB = 4;
    localparam int CA_COMA_LSB = 6;
    localparam int CB_CS_LSB = 0;
    localparam int CB_CAPSRC_BIT = 5;
    localparam int CB_CAPEDGE_BIT = 6;
    localparam int CB_NOISE_BIT = 7;
    localparam int FL_OVF = 0;
    localparam int FL_MA = 1;
    localparam int FL_MB = 2;
    localparam int FL_CAP = 3;
    localparam int PWR_OFF_BIT = 0;
    // Reset values, count maximum, response codes and default filter depth
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_FLAG = 4'h0;
    localparam logic PWR_OFF_RST = 1'b1;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int NC_DEPTH_DEF = 4;

    typedef enum logic [2:0] {
        MD_NORMAL = 3'b000,
        MD_CTC_A = 3'b001,
        MD_CTC_CAP = 3'b010,
        MD_PC_MAX = 3'b011,
        MD_PC_A = 3'b100,
        MD_PC_CAP = 3'b101
    } tcs_mode_e;

    typedef enum logic [2:0] {
        CS_NONE = 3'b000,
        CS_DIV1 = 3'b001,
        CS_DIV8 = 3'b010,
        CS_DIV64 = 3'b011,
        CS_DIV256 = 3'b100,
        CS_DIV1024 = 3'b101,
        CS_EXT_FALL = 3'b110,
        CS_EXT_RISE = 3'b111
    } tcs_clksel_e;
endpackage : tcs_pkg

/* File: bench/tcs_timer_sva.sv */
module tcs_timer_sva #(
    parameter int NC_DEPTH = tcs_pkg::NC_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [tcs_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic count_bottom,
    input wire logic [3:0] irq
);
    import tcs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Address class is latched at acceptance, since the bus may move on before the answer
    logic wbad;
    logic rbad;
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            wbad <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
            wbad <= (s_axi_awaddr > OFS_PWR) || (s_axi_awaddr[1:0] != 2'b00);
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            rbad <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            rbad <= (s_axi_araddr > OFS_PWR) || (s_axi_araddr[1:0] != 2'b00);
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while response pending");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_BRESP: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (wbad ? RESP_SLVERR : RESP_OKAY))
        else $error("write response code wrong");
    AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not next cycle");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready)
        else $error("read beat wider than a byte");
    AST_RRESP: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp == (rbad ? RESP_SLVERR : RESP_OKAY))
        else $error("read response code wrong");
    AST_RST_BOTTOM: assert property ($rose(arst_n) |-> count_bottom && irq == 4'h0)
        else $error("bottom or request wrong after reset");
endmodule // tcs_timer_sva

bind tcs_timer tcs_timer_sva #(.NC_DEPTH(NC_DEPTH)) u_sva (.clk_sys, .arst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .count_bottom, .irq);

/* File: bench/tcs_cpu_model.sv */
module tcs_cpu_model (
    input wire logic clk_sys,
    output logic [5:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [5:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Handshakes are judged at the falling edge, where they equal what the next rising edge sees
    task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        logic tb;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk_sys);
            if (ta)
            begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (tw)
            begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
        logic got;
        logic tk;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            got = rvalid;
            tk = arvalid && arready;
            d = rdata[7:0];
            r = rresp;
            @(posedge clk_sys);
            if (tk)
            begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!got);
        rready <= 1'b0;
    endtask
    task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
        logic [1:0] r;
        wr(lo + 6'h04, v[15:8], r);
        wr(lo, v[7:0], r);
    endtask
    task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
        logic [1:0] r;
        rd(lo, v[7:0], r);
        rd(lo + 6'h04, v[15:8], r);
    endtask
endmodule // tcs_cpu_model

/* File: bench/tb_top.sv */
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;
    logic clk_sys, arst_n, ext_pin, cap_pin, cmp_pin;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, wa, wa_en, wb, wb_en, cbot, ctop;
    logic [15:0] v, v2;
    logic [7:0] d;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    tcs_timer #(.NC_DEPTH(4)) dut (.clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_pin(ext_pin),
        .capture_input_pin(cap_pin), .comparator_out(cmp_pin), .waveform_out_a(wa),
        .waveform_out_a_en(wa_en), .waveform_out_b(wb), .waveform_out_b_en(wb_en),
        .count_bottom(cbot), .count_top(ctop), .irq);
    tcs_cpu_model cpu (.clk_sys, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
        .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
        .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
        .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
        .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_irq(input int b);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end while (irq[b] !== 1'b1 && n < 2000);
        `CHK("irq", 1'b1, irq[b])
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        ext_pin = 1'b0;
        cap_pin = 1'b0;
        cmp_pin = 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        cpu.rd(OFS_CTRL_A, d, r);
        `CHK("ctrl_a", RST_CTRL, d)
        cpu.rd(OFS_FLAG, d, r);
        `CHK("flags", 8'h00, d)
        cpu.rd(OFS_PWR, d, r);
        `CHK("pwr", 8'h01, d)
        `CHK("bottom", 1'b1, cbot)
        $display("test reset finished");
        cpu.wr16(OFS_CNT_L, 16'h01ff);
        cpu.rd16(OFS_CNT_L, v);
        `CHK("cnt16", 16'h01ff, v)
        `CHK("bottom", 1'b0, cbot)
        cpu.wr(OFS_CMPA_H, 8'hab, r);
        cpu.wr(OFS_CNT_L, 8'h12, r);
        cpu.rd(OFS_CNT_H, d, r);
        `CHK("latch", 8'hab, d)
        cpu.rd(OFS_CMPA_H, d, r);
        `CHK("cmpa_h", 8'h00, d)
        cpu.wr16(OFS_CMPA_L, 16'h3456);
        cpu.rd(OFS_CNT_L, d, r);
        cpu.rd(OFS_CMPA_H, d, r);
        `CHK("cmpa_h", 8'h34, d)
        cpu.wr(6'h34, 8'h55, r);
        `CHK("wr_resp", RESP_SLVERR, r)
        cpu.rd(6'h2a, d, r);
        `CHK("rd_resp", RESP_SLVERR, r)
        `CHK("rd_zero", 8'h00, d)
        $display("test byte access finished");
        cpu.wr16(OFS_CMPA_L, 16'h0005);
        cpu.wr16(OFS_CMPB_L, 16'h0003);
        cpu.wr16(OFS_CNT_L, 16'h0000);
        cpu.wr(OFS_CTRL_A, 8'h41, r);
        `CHK("en_a", 1'b1, wa_en)
        cpu.wr(OFS_MASK, 8'h06, r);
        cpu.wr(OFS_PWR, 8'h00, r);
        cpu.wr(OFS_CTRL_B, 8'h01, r);
        wait_irq(1);
        wait_irq(2);
        cpu.wr(OFS_CTRL_B, 8'h00, r);
        cpu.rd16(OFS_CNT_L, v);
        `CHK("ctc_top", 1'b1, v <= 16'h0005)
        repeat (20) @(posedge clk_sys);
        cpu.rd16(OFS_CNT_L, v2);
        `CHK("stopped", v, v2)
        `CHK("irq_ab", 4'h6, irq)
        cpu.wr(OFS_MASK, 8'h02, r);
        `CHK("irq_a", 4'h2, irq)
        cpu.wr(OFS_FLAG, 8'h0f, r);
        `CHK("irq_clr", 4'h0, irq)
        cpu.wr16(OFS_CNT_L, 16'h0005);
        `CHK("top", 1'b1, ctop)
        cpu.wr(OFS_CTRL_A, 8'hc1, r);
        cpu.wr(OFS_CTRL_B, 8'h01, r);
        cpu.wr(OFS_CTRL_B, 8'h00, r);
        `CHK("wave_a", 1'b1, wa)
        `CHK("en_b", 1'b0, wb_en)
        cpu.wr(OFS_CTRL_A, 8'h44, r);
        `CHK("en_a_pwm", 1'b0, wa_en)
        cpu.wr(OFS_CTRL_A, 8'h00, r);
        $display("test compare finished");
        cpu.wr16(OFS_CNT_L, 16'h0000);
        cpu.wr(OFS_CTRL_B, 8'h07, r);
        repeat (5)
        begin
            @(posedge clk_sys) ext_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ext_pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        cpu.wr(OFS_CTRL_B, 8'h00, r);
        cpu.rd16(OFS_CNT_L, v);
        `CHK("ext_cnt", 16'h0005, v)
        $display("test external finished");
        cpu.wr16(OFS_CNT_L, 16'h0777);
        cpu.wr(OFS_CTRL_B, 8'h40, r);
        cpu.wr(OFS_MASK, 8'h08, r);
        @(posedge clk_sys) cap_pin <= 1'b1;
        wait_irq(3);
        cpu.rd16(OFS_CAP_L, v);
        `CHK("capture", 16'h0777, v)
        // Comparator source, falling edge, filter on; held high first so no edge on the switch
        @(posedge clk_sys) cmp_pin <= 1'b1;
        cpu.wr(OFS_CTRL_B, 8'ha0, r);
        cpu.wr16(OFS_CNT_L, 16'h0123);
        cpu.wr(OFS_FLAG, 8'h0f, r);
        @(posedge clk_sys) cmp_pin <= 1'b0;
        @(posedge clk_sys) cmp_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK("glitch", 1'b0, irq[3])
        @(posedge clk_sys) cmp_pin <= 1'b0;
        wait_irq(3);
        cpu.rd16(OFS_CAP_L, v);
        `CHK("cap_filt", 16'h0123, v)
        $display("test capture finished");
        cpu.wr(OFS_FLAG, 8'h0f, r);
        cpu.wr16(OFS_CNT_L, 16'hfffd);
        cpu.wr(OFS_MASK, 8'h01, r);
        cpu.wr(OFS_CTRL_B, 8'h01, r);
        wait_irq(0);
        $display("test overflow finished");
        finish_test();
    end
endmodule // tb_top
